// ==== core/readout_pkg.sv ====
package readout_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int          POS_W         = 12;
    localparam int          GRID_PIXELS   = 24;
    localparam logic [6:0]  COL_START_MAX = 7'h62;
    localparam logic [7:0]  ROW_START_MAX = 8'h89;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS      = 8000;
    localparam int          ROW_BLANKING_NS    = 7200;
    localparam int          PIXEL_PERIOD_NS    = 25;
    // least times: round up to whole cycles
    localparam int          ROW_BLANKING_CYC   = (ROW_BLANKING_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          PIXEL_PERIOD_CYC   = (PIXEL_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [9:0]  BLANK_LAST         = 10'(ROW_BLANKING_CYC - 1);
    localparam logic [9:0]  BLANK_SIG_SAMPLE   = 10'(ROW_BLANKING_CYC / 4);
    localparam logic [9:0]  BLANK_PIXEL_RESET  = 10'(ROW_BLANKING_CYC / 2);
    localparam logic [9:0]  BLANK_RST_SAMPLE   = 10'((ROW_BLANKING_CYC * 3) / 4);
    localparam logic [2:0]  PIX_DIV_LAST       = 3'(PIXEL_PERIOD_CYC - 1);

    // ------------------------------------------------------------------
    // subsampling steps
    // ------------------------------------------------------------------
    localparam logic [3:0]  STEP_A = 4'h2;
    localparam logic [3:0]  STEP_B = 4'h4;
    localparam logic [3:0]  STEP_C = 4'h6;
    localparam logic [3:0]  STEP_D = 4'h8;
    localparam logic [3:0]  STEP_E = 4'hC;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_wait  = 4'h2,
        st_blank = 4'h4,
        st_line  = 4'h8
    } seq_state_t;

    function automatic logic [3:0] step_of(input logic [2:0] code);
        logic [3:0] s;
        s = STEP_E;
        case (code)
            3'h0: s = STEP_A;
            3'h1: s = STEP_B;
            3'h2: s = STEP_C;
            3'h3: s = STEP_D;
            default: s = STEP_E;
        endcase
        return s;
    endfunction

endpackage

// ==== core/step_if.sv ====
`timescale 1ns/1ps
interface step_if #(parameter int W = 12);
    logic          load;
    logic [W-1:0]  start;
    logic          step;
    logic [2:0]    code;
    logic [W-1:0]  pos;

    modport ctrl    (output load, output start, output step, output code, input pos);
    modport stepper (input load, input start, input step, input code, output pos);
endinterface

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      rise
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // meta_ff feeds only sync_ff
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~last_ff;
endmodule

// ==== core/addr_stepper.sv ====
`timescale 1ns/1ps
module addr_stepper #(
    parameter bit PAIRED = 1'b0,
    parameter int W      = 12
) (
    input  wire logic clk,
    input  wire logic nrst,
    step_if.stepper   s
);
    logic [W-1:0] pos_ff;
    logic [W-1:0] nxt_pos;
    logic         phase_ff;
    logic         nxt_phase;
    wire  [W-1:0] step_w = W'(readout_pkg::step_of(s.code));

    // ------------------------------------------------------------------
    // paired columns advance a whole step per pair; single rows read
    // two neighbours and then skip the remainder of the step
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pos   = pos_ff;
        nxt_phase = phase_ff;
        if (s.load) begin
            nxt_pos   = s.start;
            nxt_phase = 1'b0;
        end else if (s.step) begin
            if (PAIRED) begin
                nxt_pos = pos_ff + step_w;
            end else begin
                nxt_pos   = phase_ff ? pos_ff + step_w - W'(1) : pos_ff + W'(1);
                nxt_phase = ~phase_ff;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_ff   <= '0;
            phase_ff <= 1'b0;
        end else begin
            pos_ff   <= nxt_pos;
            phase_ff <= nxt_phase;
        end
    end

    assign s.pos = pos_ff;
endmodule

// ==== core/image_array_readout_sequencer.sv ====
// Function
// - frame time is lines times row blanking plus pixels times pixel period
// - row start loads on frame start, column start loads on each row clock
// - window starts sit on a 24 pixel grid
// - read two adjacent pixels then step 2, 4, 6, 8 or 12 by code
// - column start has 99 positions, row start 138
// - columns are addressed in odd/even pairs, rows one at a time
// - separate read and reset row pointers, both moved by the row clock
// - dual-side drive bit or nondestructive modes 1 and 2 drive rows from both sides
// - normal readout double samples: signal, pixel reset, reset level
// - nondestructive readout never resets between reads; controller stores samples
// - column start accepts 0 to 98, row start 0 to 137
`timescale 1ns/1ps
module image_array_readout_sequencer (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        frame_start_pin,
    input  wire logic        row_clock_pin,
    input  wire logic [6:0]  col_start,
    input  wire logic [7:0]  row_start,
    input  wire logic [2:0]  x_subsample,
    input  wire logic [2:0]  y_subsample,
    input  wire logic [11:0] int_rows,
    input  wire logic [10:0] nof_pixels,
    input  wire logic [11:0] nof_lines,
    input  wire logic        dual_side_drive,
    input  wire logic        nondestructive_readout,
    input  wire logic [1:0]  multi_read_mode,
    output logic      [11:0] read_row,
    output logic      [11:0] reset_row,
    output logic      [11:0] col_addr,
    output logic             col_valid,
    output logic             row_select_near,
    output logic             row_select_far,
    output logic             shutter_reset_near,
    output logic             shutter_reset_far,
    output logic             pixel_reset,
    output logic             sample_signal,
    output logic             sample_reset,
    output logic             frame_active,
    output logic             line_done,
    output logic             frame_done
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic fs_rise;
    logic rc_rise;

    pin_sync u_fs_sync (
        .clk  (clk),
        .nrst (nrst),
        .pin  (frame_start_pin),
        .rise (fs_rise)
    );

    pin_sync u_rc_sync (
        .clk  (clk),
        .nrst (nrst),
        .pin  (row_clock_pin),
        .rise (rc_rise)
    );

    // ------------------------------------------------------------------
    // window start decode
    // ------------------------------------------------------------------
    // out-of-range starts clamp to the last legal coordinate
    wire [6:0]  col_idx = (col_start > readout_pkg::COL_START_MAX) ? readout_pkg::COL_START_MAX : col_start;
    wire [7:0]  row_idx = (row_start > readout_pkg::ROW_START_MAX) ? readout_pkg::ROW_START_MAX : row_start;
    wire [11:0] col_pos = 12'(col_idx * readout_pkg::GRID_PIXELS);
    wire [11:0] row_pos = 12'(row_idx * readout_pkg::GRID_PIXELS);
    wire [11:0] rst_pos = row_pos + int_rows;

    // non-destructive modes 1 and 2 combine both shift registers
    wire multi_read_dual = nondestructive_readout & ((multi_read_mode == 2'h1) | (multi_read_mode == 2'h2));
    wire both_side       = dual_side_drive | multi_read_dual;

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    readout_pkg::seq_state_t state_ff;
    readout_pkg::seq_state_t nxt_state;

    logic [9:0]  blank_cnt_ff;
    logic [2:0]  pix_div_ff;
    logic [10:0] pix_cnt_ff;
    logic [11:0] line_cnt_ff;
    logic        first_row_ff;

    wire in_idle  = (state_ff == readout_pkg::st_idle);
    wire in_blank = (state_ff == readout_pkg::st_blank);
    wire in_line  = (state_ff == readout_pkg::st_line);

    // a row clock before the first frame start is ignored
    wire row_evt   = rc_rise & ~in_idle & ~fs_rise;
    wire blank_end = in_blank & (blank_cnt_ff == readout_pkg::BLANK_LAST);
    wire pix_tick  = in_line & (pix_div_ff == readout_pkg::PIX_DIV_LAST);
    wire line_end  = pix_tick & ((pix_cnt_ff + 11'h001) >= nof_pixels);
    wire last_line = (line_cnt_ff + 12'h001) >= nof_lines;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            readout_pkg::st_idle: begin
                if (fs_rise) begin
                    nxt_state = readout_pkg::st_wait;
                end
            end
            readout_pkg::st_wait: begin
                if (fs_rise) begin
                    nxt_state = readout_pkg::st_wait;
                end else if (row_evt) begin
                    nxt_state = readout_pkg::st_blank;
                end
            end
            readout_pkg::st_blank: begin
                if (fs_rise) begin
                    nxt_state = readout_pkg::st_wait;
                end else if (row_evt) begin
                    nxt_state = readout_pkg::st_blank;
                end else if (blank_end) begin
                    nxt_state = readout_pkg::st_line;
                end
            end
            readout_pkg::st_line: begin
                if (fs_rise) begin
                    nxt_state = readout_pkg::st_wait;
                end else if (row_evt) begin
                    nxt_state = readout_pkg::st_blank;
                end else if (line_end) begin
                    nxt_state = last_line ? readout_pkg::st_idle : readout_pkg::st_wait;
                end
            end
            default: begin
                nxt_state = readout_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= readout_pkg::st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // blanking and pixel timing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blank_cnt_ff <= 10'h000;
        end else if (row_evt || !in_blank) begin
            blank_cnt_ff <= 10'h000;
        end else begin
            blank_cnt_ff <= blank_cnt_ff + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pix_div_ff <= 3'h0;
        end else if (!in_line || pix_tick) begin
            pix_div_ff <= 3'h0;
        end else begin
            pix_div_ff <= pix_div_ff + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pix_cnt_ff <= 11'h000;
        end else if (!in_line) begin
            pix_cnt_ff <= 11'h000;
        end else if (pix_tick) begin
            pix_cnt_ff <= pix_cnt_ff + 11'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_cnt_ff <= 12'h000;
        end else if (fs_rise) begin
            line_cnt_ff <= 12'h000;
        end else if (line_end) begin
            line_cnt_ff <= line_cnt_ff + 12'h001;
        end
    end

    // the first row clock of a frame selects the loaded start row itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_row_ff <= 1'b0;
        end else if (fs_rise) begin
            first_row_ff <= 1'b1;
        end else if (row_evt) begin
            first_row_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // address steppers
    // ------------------------------------------------------------------
    step_if #(.W(readout_pkg::POS_W)) col_if ();
    step_if #(.W(readout_pkg::POS_W)) rd_if ();
    step_if #(.W(readout_pkg::POS_W)) rs_if ();

    assign col_if.load  = row_evt;
    assign col_if.start = col_pos;
    assign col_if.step  = pix_tick & pix_cnt_ff[0];
    assign col_if.code  = x_subsample;

    assign rd_if.load   = fs_rise;
    assign rd_if.start  = row_pos;
    assign rd_if.step   = row_evt & ~first_row_ff;
    assign rd_if.code   = y_subsample;

    assign rs_if.load   = fs_rise;
    assign rs_if.start  = rst_pos;
    assign rs_if.step   = row_evt & ~first_row_ff;
    assign rs_if.code   = y_subsample;

    addr_stepper #(.PAIRED(1'b1), .W(readout_pkg::POS_W)) u_col_step (
        .clk  (clk),
        .nrst (nrst),
        .s    (col_if)
    );

    addr_stepper #(.PAIRED(1'b0), .W(readout_pkg::POS_W)) u_read_step (
        .clk  (clk),
        .nrst (nrst),
        .s    (rd_if)
    );

    addr_stepper #(.PAIRED(1'b0), .W(readout_pkg::POS_W)) u_reset_step (
        .clk  (clk),
        .nrst (nrst),
        .s    (rs_if)
    );

    assign read_row  = rd_if.pos;
    assign reset_row = rs_if.pos;
    assign col_addr  = col_if.pos;

    // ------------------------------------------------------------------
    // row drive and sampling strobes
    // ------------------------------------------------------------------
    logic col_valid_ff;
    logic row_sel_near_ff;
    logic row_sel_far_ff;
    logic sh_rst_near_ff;
    logic sh_rst_far_ff;
    logic pix_rst_ff;
    logic smp_sig_ff;
    logic smp_rst_ff;
    logic frame_active_ff;
    logic line_done_ff;
    logic frame_done_ff;

    wire row_on   = (nxt_state == readout_pkg::st_blank) | (nxt_state == readout_pkg::st_line);
    // a nondestructive read leaves the pixel charge in place
    wire do_reset = ~nondestructive_readout;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            col_valid_ff    <= 1'b0;
            row_sel_near_ff <= 1'b0;
            row_sel_far_ff  <= 1'b0;
            sh_rst_near_ff  <= 1'b0;
            sh_rst_far_ff   <= 1'b0;
            pix_rst_ff      <= 1'b0;
            smp_sig_ff      <= 1'b0;
            smp_rst_ff      <= 1'b0;
            frame_active_ff <= 1'b0;
            line_done_ff    <= 1'b0;
            frame_done_ff   <= 1'b0;
        end else begin
            col_valid_ff    <= nxt_state == readout_pkg::st_line;
            row_sel_near_ff <= row_on;
            row_sel_far_ff  <= row_on & both_side;
            sh_rst_near_ff  <= row_evt & both_side;
            sh_rst_far_ff   <= row_evt;
            smp_sig_ff      <= in_blank & ~row_evt & (blank_cnt_ff == readout_pkg::BLANK_SIG_SAMPLE);
            pix_rst_ff      <= in_blank & ~row_evt & do_reset & (blank_cnt_ff == readout_pkg::BLANK_PIXEL_RESET);
            smp_rst_ff      <= in_blank & ~row_evt & do_reset & (blank_cnt_ff == readout_pkg::BLANK_RST_SAMPLE);
            frame_active_ff <= nxt_state != readout_pkg::st_idle;
            line_done_ff    <= line_end & ~fs_rise & ~row_evt;
            frame_done_ff   <= line_end & last_line & ~fs_rise & ~row_evt;
        end
    end

    assign col_valid          = col_valid_ff;
    assign row_select_near    = row_sel_near_ff;
    assign row_select_far     = row_sel_far_ff;
    assign shutter_reset_near = sh_rst_near_ff;
    assign shutter_reset_far  = sh_rst_far_ff;
    assign pixel_reset        = pix_rst_ff;
    assign sample_signal      = smp_sig_ff;
    assign sample_reset       = smp_rst_ff;
    assign frame_active       = frame_active_ff;
    assign line_done          = line_done_ff;
    assign frame_done         = frame_done_ff;

endmodule

// ==== test/readout_assertions.sv ====
`timescale 1ns/1ps
module readout_assertions (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        dual_side_drive,
    input wire logic        nondestructive_readout,
    input wire logic [1:0]  multi_read_mode,
    input wire logic [11:0] read_row,
    input wire logic [11:0] reset_row,
    input wire logic [11:0] col_addr,
    input wire logic        col_valid,
    input wire logic        row_select_near,
    input wire logic        row_select_far,
    input wire logic        shutter_reset_near,
    input wire logic        shutter_reset_far,
    input wire logic        pixel_reset,
    input wire logic        sample_signal,
    input wire logic        sample_reset,
    input wire logic        frame_active,
    input wire logic        line_done,
    input wire logic        frame_done
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic        both;
    logic [11:0] gap;
    assign both = dual_side_drive | (nondestructive_readout & (multi_read_mode == 2'h1 || multi_read_mode == 2'h2));
    // the pointer distance must survive every row step, so watch it as one value
    assign gap  = reset_row - read_row;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_far_select_mode: assert property (row_select_far == (row_select_near && $past(both)))
        else $error("far row select does not follow drive mode");
    a_near_shutter_mode: assert property (shutter_reset_near == (shutter_reset_far && $past(both)))
        else $error("near shutter pulse does not follow drive mode");
    a_pair_even_col: assert property (col_valid |-> col_addr[0] == 1'b0)
        else $error("column pair address is odd");
    a_shutter_in_frame: assert property (shutter_reset_far |-> frame_active)
        else $error("row accepted outside a frame");
    a_pointer_gap_kept: assert property (frame_active && $past(frame_active) |-> gap == $past(gap))
        else $error("read and reset pointers moved apart");
    a_pointer_moves_row: assert property ($changed(read_row) |-> shutter_reset_far || $rose(frame_active))
        else $error("read pointer moved without row clock or frame start");
    a_blank_no_valid: assert property (shutter_reset_far |=> !col_valid [*8])
        else $error("pixels valid during row blanking");
    a_line_pixels_run: assert property ($rose(col_valid) |-> col_valid [*8])
        else $error("pixel phase shorter than two pixels");
    a_hold_no_reset: assert property (nondestructive_readout && $past(nondestructive_readout)
                                      |-> !pixel_reset && !sample_reset)
        else $error("pixel reset during nondestructive readout");
    a_frame_end_line: assert property (frame_done |-> line_done ##1 !frame_active)
        else $error("frame end not on last line end");
    a_strobe_in_blank: assert property (sample_signal |-> !col_valid && row_select_near)
        else $error("signal sample outside row blanking");
endmodule

// ==== test/camera_ctrl_model.sv ====
`timescale 1ns/1ps
module camera_ctrl_model (
    input  wire logic clk,
    input  wire logic sample_signal,
    input  wire logic sample_reset,
    output logic      frame_start_pin,
    output logic      row_clock_pin
);
    int stored_samples;

    initial begin
        frame_start_pin = 1'b0;
        row_clock_pin = 1'b0;
        stored_samples = 0;
    end

    // the controller, not the device, keeps reset level and samples
    always @(posedge clk) begin
        if (sample_signal || sample_reset) begin
            stored_samples <= stored_samples + 1;
        end
    end

    // ------------------------------------------------------------------
    // pins stay high and low three cycles, one more than the sync needs
    // ------------------------------------------------------------------
    task automatic pulse_frame_start();
        @(posedge clk);
        #1 frame_start_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1 frame_start_pin = 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse_row_clock();
        @(posedge clk);
        #1 row_clock_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1 row_clock_pin = 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ==== test/test_image_array_readout_sequencer.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module test_image_array_readout_sequencer;
    logic        clk, nrst, frame_start_pin, row_clock_pin;
    logic [6:0]  col_start;
    logic [7:0]  row_start;
    logic [2:0]  x_subsample, y_subsample;
    logic [11:0] int_rows, nof_lines, read_row, reset_row, col_addr, xstep, prev_a;
    logic [10:0] nof_pixels;
    logic        dual_side_drive, nondestructive_readout, col_valid, row_select_near, row_select_far;
    logic [1:0]  multi_read_mode;
    logic        shutter_reset_near, shutter_reset_far, pixel_reset, sample_signal, sample_reset;
    logic        frame_active, line_done, frame_done, prev_v, fd_seen;
    int          err_count, checks_done, cycles, rel, shut_cnt;
    int          n_sig, n_prst, n_srst, t_sig, t_prst, t_srst, t_val, v_cnt;

    image_array_readout_sequencer image_array_readout_sequencer_i (.*);
    camera_ctrl_model camera_ctrl_model_i (.clk(clk), .sample_signal(sample_signal), .sample_reset(sample_reset),
        .frame_start_pin(frame_start_pin), .row_clock_pin(row_clock_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // line monitor: timing of strobes and pixels relative to the row clock
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        rel <= rel + 1;
        if (shutter_reset_far) begin
            rel <= 1;
            {n_sig, n_prst, n_srst, v_cnt, fd_seen} <= '0;
            shut_cnt <= shut_cnt + 1;
        end
        if (sample_signal) begin n_sig <= n_sig + 1; t_sig <= rel; end
        if (pixel_reset) begin n_prst <= n_prst + 1; t_prst <= rel; end
        if (sample_reset) begin n_srst <= n_srst + 1; t_srst <= rel; end
        if (col_valid && !prev_v) t_val <= rel;
        if (col_valid) v_cnt <= v_cnt + 1;
        if (col_valid && prev_v && col_addr !== prev_a) `CHK("column step", xstep, 12'(col_addr - prev_a))
        if (frame_done) fd_seen <= 1'b1;
        prev_v <= col_valid;
        prev_a <= col_addr;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            conclude();
        end
    end

    function automatic logic [11:0] exp_step(input logic [2:0] c);
        return c[2] ? 12'hC : 12'({c[1:0], 1'b0}) + 12'h2;
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_on(input int sel, input int lim);
        int k;
        logic hit;
        k = 0;
        hit = 1'b0;
        while (!hit && k < lim) begin
            @(posedge clk);
            #1;
            hit = (sel == 0) ? frame_active : (sel == 1) ? shutter_reset_far : line_done;
            k++;
        end
        `CHK("handshake", 1'b1, hit)
    endtask

    // ------------------------------------------------------------------
    // one frame: corner windows first, then every step code, then random
    // ------------------------------------------------------------------
    task automatic run_frame(input int i);
        logic [11:0] rpos, cpos, er;
        logic [15:0] cfg;
        logic [1:0]  drv;
        int          s0;
        @(posedge clk);
        #1;
        col_start = (i == 0) ? 7'h62 : (i == 1) ? 7'h7F : 7'($urandom);
        row_start = (i == 0) ? 8'h89 : (i == 1) ? 8'hFF : 8'($urandom);
        x_subsample = (i < 8) ? 3'(i) : 3'($urandom);
        y_subsample = (i < 8) ? 3'(7 - i) : 3'($urandom);
        cfg = 16'($urandom);
        int_rows = (i == 0) ? 12'hFFF : cfg[11:0];
        nof_pixels = 11'(4 + 2 * ($urandom % 3));
        nof_lines = 12'(2 + $urandom % 3);
        dual_side_drive = (i == 2) || (i > 3 && $urandom % 2 == 1);
        nondestructive_readout = (i == 1) || (i == 3) || (i > 3 && $urandom % 2 == 1);
        multi_read_mode = (i == 1) ? 2'h1 : (i == 3) ? 2'h0 : 2'($urandom);
        xstep = exp_step(x_subsample);
        cpos = 12'((col_start > readout_pkg::COL_START_MAX ? readout_pkg::COL_START_MAX : col_start) * 24);
        rpos = 12'((row_start > readout_pkg::ROW_START_MAX ? readout_pkg::ROW_START_MAX : row_start) * 24);
        fork
            camera_ctrl_model_i.pulse_frame_start();
            wait_on(0, 20);
        join
        `CHK("read start", rpos, read_row)
        `CHK("reset start", 12'(rpos + int_rows), reset_row)
        for (int l = 0; l < int'(nof_lines); l++) begin
            fork
                camera_ctrl_model_i.pulse_row_clock();
                wait_on(1, 20);
            join
            er = rpos + 12'((l / 2) * exp_step(y_subsample)) + 12'(l % 2);
            `CHK("read row", er, read_row)
            `CHK("reset row", 12'(er + int_rows), reset_row)
            `CHK("column start", cpos, col_addr)
            drv = {1'b1, dual_side_drive | (nondestructive_readout & (multi_read_mode inside {2'h1, 2'h2}))};
            `CHK("row drive", drv, {row_select_near, row_select_far})
            s0 = camera_ctrl_model_i.stored_samples;
            wait_on(2, 1100);
            @(posedge clk);
            #1;
            `CHK("signal samples", 1, n_sig)
            `CHK("pixel resets", nondestructive_readout ? 0 : 1, n_prst)
            `CHK("reset samples", nondestructive_readout ? 0 : 1, n_srst)
            if (!nondestructive_readout) `CHK("strobe order", 1'b1, t_sig < t_prst && t_prst < t_srst)
            `CHK("blanking cycles", readout_pkg::ROW_BLANKING_CYC, t_val)
            `CHK("pixel cycles", int'(nof_pixels) * readout_pkg::PIXEL_PERIOD_CYC, v_cnt)
            `CHK("frame end", l == int'(nof_lines) - 1, fd_seen)
            `CHK("stored samples", s0 + (nondestructive_readout ? 1 : 2), camera_ctrl_model_i.stored_samples)
        end
        $display("test %0d done", i);
    endtask

    initial begin
        {nrst, col_start, row_start, x_subsample, y_subsample, int_rows, nof_pixels, nof_lines} = '0;
        {dual_side_drive, nondestructive_readout, multi_read_mode, xstep, prev_a, prev_v, fd_seen} = '0;
        {err_count, checks_done, cycles, rel, shut_cnt, n_sig, n_prst, n_srst, t_sig, t_prst, t_srst} = '0;
        {t_val, v_cnt} = '0;
        void'($urandom(32));
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        // a row clock before any frame start must be ignored
        camera_ctrl_model_i.pulse_row_clock();
        repeat (5) @(posedge clk);
        `CHK("idle row clock", 0, shut_cnt)
        $display("test idle done");
        for (int i = 0; i < 12; i++) begin
            run_frame(i);
        end
        conclude();
    end
endmodule

bind image_array_readout_sequencer readout_assertions readout_assertions_i (.clk(clk), .nrst(nrst),
    .dual_side_drive(dual_side_drive), .nondestructive_readout(nondestructive_readout),
    .multi_read_mode(multi_read_mode),
    .read_row(read_row), .reset_row(reset_row), .col_addr(col_addr), .col_valid(col_valid),
    .row_select_near(row_select_near), .row_select_far(row_select_far), .shutter_reset_near(shutter_reset_near),
    .shutter_reset_far(shutter_reset_far), .pixel_reset(pixel_reset), .sample_signal(sample_signal),
    .sample_reset(sample_reset), .frame_active(frame_active), .line_done(line_done), .frame_done(frame_done));
